// ---- sfll_defines.svh ----
// Constants for the spindle speed-lock-loop register block
`ifndef SFLL_DEFINES_SVH
`define SFLL_DEFINES_SVH
`define SFLL_ADDR_CTRL_B 4'h4
`define SFLL_ADDR_COARSE 4'h5
`define SFLL_ADDR_FINE 4'h6
`define SFLL_ADDR_ERROR 4'h7
`define SFLL_DATA_W 12
`define SFLL_ADDR_BITS 5'h04
`define SFLL_FRAME_BITS 5'h10
`define SFLL_CTRL_B_RST 12'h000
`define SFLL_PERIOD_RST 12'h000
`define SFLL_GAIN_LSB 0
`define SFLL_GAIN_MSB 2
`define SFLL_FB_SRC_BIT 3
`define SFLL_HALVE_BIT 4
`define SFLL_POS_SEL_BIT 5
`define SFLL_SENSE_BIT 6
`define SFLL_SLEW_LSB 7
`define SFLL_SLEW_MSB 9
`define SFLL_SLEW_RES_BIT 10
`define SFLL_MASK_BIT 11
// Slowest clock and step limits; counts are in prescaled ticks at that clock
`define SFLL_SLOW_CLK_MHZ 4
`define SFLL_COARSE_STEP_US 16
`define SFLL_FINE_STEP_US 1
`define SFLL_SLOW_TICK_MHZ (`SFLL_SLOW_CLK_MHZ / 2)
`define SFLL_FINE_TICKS (`SFLL_FINE_STEP_US * `SFLL_SLOW_TICK_MHZ)
`define SFLL_COARSE_TICKS (`SFLL_COARSE_STEP_US * `SFLL_SLOW_TICK_MHZ)
`endif

// ---- sfll_pkg.sv ----
// Types for the spindle speed-lock-loop register block
`default_nettype none
package sfll_pkg;
    typedef enum logic [1:0] {SFLL_IDLE, SFLL_COARSE, SFLL_FINE} sfll_meas_t;
endpackage
`default_nettype wire

// ---- sfll_period_meas.sv ----
// Rotation period measurement producing the fine error count
`include "sfll_defines.svh"
`default_nettype none
module sfll_period_meas
    import sfll_pkg::*;
#(
    parameter int ELEC_PER_REV = 4,
    parameter int FINE_TICKS = `SFLL_FINE_TICKS,
    parameter int COARSE_TICKS = `SFLL_COARSE_TICKS
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic tick, // Prescaled time base
    input wire logic cycle_evt, // One pulse per electrical cycle
    input wire logic cycle_kind_sel, // 1 electrical, 0 mechanical
    input wire logic [11:0] coarse_period_value, // Coarse target
    input wire logic [11:0] fine_period_value, // Fine target
    output logic [11:0] fine_error_value // Fine error count
);
    sfll_meas_t st_ff, nxt_st;
    logic [5:0] div_ff, nxt_div;
    logic [11:0] cnt_ff, nxt_cnt;
    logic [3:0] rev_ff, nxt_rev;
    logic [11:0] err_ff, nxt_err;
    logic period_end;

    // Electrical cycle or whole revolution closes a period
    assign period_end = cycle_evt && (cycle_kind_sel || 
        (rev_ff == 4'(ELEC_PER_REV - 1)));

    // Coarse countdown then fine count until the period ends
    always_comb begin
        nxt_st = st_ff;
        nxt_div = div_ff;
        nxt_cnt = cnt_ff;
        nxt_rev = rev_ff;
        nxt_err = err_ff;
        if (cycle_evt) begin
            nxt_rev = (period_end || cycle_kind_sel) ? 4'h0 : rev_ff + 4'h1;
        end
        if (period_end) begin
            if (st_ff == SFLL_FINE) begin
                nxt_err = fine_period_value - cnt_ff;
            end else if (st_ff == SFLL_COARSE) begin
                nxt_err = fine_period_value;
            end
            nxt_st = SFLL_COARSE;
            nxt_div = 6'h00;
            nxt_cnt = coarse_period_value;
        end else if (tick) begin
            case (st_ff)
                SFLL_COARSE: begin
                    if (div_ff == 6'(COARSE_TICKS - 1)) begin
                        nxt_div = 6'h00;
                        if (cnt_ff <= 12'h001) begin
                            nxt_st = SFLL_FINE;
                            nxt_cnt = 12'h000;
                        end else begin
                            nxt_cnt = cnt_ff - 12'h001;
                        end
                    end else begin
                        nxt_div = div_ff + 6'h01;
                    end
                end
                SFLL_FINE: begin
                    if (div_ff == 6'(FINE_TICKS - 1)) begin
                        nxt_div = 6'h00;
                        if (cnt_ff != 12'hfff) begin
                            nxt_cnt = cnt_ff + 12'h001;
                        end
                    end else begin
                        nxt_div = div_ff + 6'h01;
                    end
                end
                default: nxt_st = st_ff;
            endcase
        end
    end

    // Measurement state registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff <= SFLL_IDLE;
            div_ff <= 6'h00;
            cnt_ff <= 12'h000;
            rev_ff <= 4'h0;
            err_ff <= 12'h000;
        end else begin
            st_ff <= nxt_st;
            div_ff <= nxt_div;
            cnt_ff <= nxt_cnt;
            rev_ff <= nxt_rev;
            err_ff <= nxt_err;
        end
    end

    assign fine_error_value = err_ff;
endmodule // sfll_period_meas
`default_nettype wire

// ---- sfll_regs.sv ----
// Serial register port and control outputs of the speed-lock loop
`include "sfll_defines.svh"
`default_nettype none
module sfll_regs
    import sfll_pkg::*;
#(
    parameter int ELEC_PER_REV = 4
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic sclk, // Serial clock
    input wire logic sload_n, // Port select, low active
    input wire logic rw, // 1 read, 0 write
    input wire logic sdio_in, // Serial data pin in
    output logic sdio_out, // Serial data pin out
    output logic sdio_oe_n, // Serial data drive, low drives
    input wire logic cycle_kind_sel, // 1 electrical, 0 mechanical
    input wire logic bemf_cross_pulse, // Back-EMF comparator crossing
    input wire logic zero_cross_cycle_pulse, // Once per electrical cycle
    input wire logic digital_test_in, // Test pin level in
    input wire logic test_drive_value, // Test value to put on pin
    output logic digital_test_out, // Test pin drive value
    output logic digital_test_oe_n, // Test pin drive, low drives
    output logic [2:0] loop_gain_sel, // Gain code
    output logic [3:0] loop_gain_factor, // Gain factor 1 to 8
    output logic feedback_source_sel, // 1 external feedback
    output logic speed_feedback, // Loop feedback pulse
    output logic clock_halve_sel, // 1 halves internal clock
    output logic clock_tick, // Prescaled time base
    output logic position_pulse_sel, // Position output select
    output logic position_pulse, // Synthesized position pulse
    output logic sense_transistor_gain, // 1 low gain
    output logic [2:0] slew_code, // Slew rate code
    output logic slew_internal_res, // 1 internal resistor
    output logic mask_short_sel, // 1 short mask angle
    output logic [11:0] coarse_period_value, // Coarse target
    output logic [11:0] fine_period_value, // Fine target
    output logic [11:0] fine_error_value // Fine error count
);
    logic [11:0] ctrl_b_ff, nxt_ctrl_b;
    logic [11:0] coarse_ff, nxt_coarse;
    logic [11:0] fine_ff, nxt_fine;
    logic [4:0] bit_cnt_ff, nxt_bit_cnt;
    logic [3:0] addr_ff, nxt_addr;
    logic [11:0] shift_ff, nxt_shift;
    logic sclk_q_ff;
    logic half_ff, nxt_half;
    logic pos_ff, nxt_pos;
    logic fb_ff, nxt_fb;
    logic fb_evt;
    logic sclk_rise;
    logic [3:0] addr_now;

    logic wr_commit;
    logic [11:0] wr_data;

    // Read data for an address; write-only and unmapped read zero
    function automatic logic [11:0] read_data(input logic [3:0] a, input logic [11:0] err);
        case (a)
            `SFLL_ADDR_ERROR: read_data = err;
            default: read_data = 12'h000;
        endcase
    endfunction

    // Serial clock edge and incoming address bit
    assign sclk_rise = sclk && !sclk_q_ff;
    assign addr_now = {sdio_in, addr_ff[3:1]};

    // Serial frame: 4 address bits then 12 data bits, LSB first
    always_comb begin
        nxt_bit_cnt = bit_cnt_ff;
        nxt_addr = addr_ff;
        nxt_shift = shift_ff;
        if (sload_n) begin
            nxt_bit_cnt = 5'h00;
        end else if (sclk_rise && bit_cnt_ff != `SFLL_FRAME_BITS) begin
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
            if (bit_cnt_ff < `SFLL_ADDR_BITS) begin
                nxt_addr = addr_now;
                if (bit_cnt_ff == `SFLL_ADDR_BITS - 5'h01) begin
                    nxt_shift = read_data(addr_now, fine_error_value);
                end
            end else if (rw) begin
                nxt_shift = {1'b0, shift_ff[11:1]};
            end else begin
                nxt_shift = {sdio_in, shift_ff[11:1]};
            end
        end
    end

    // Serial port bit count, address and shift storage
    always_ff @(posedge mclk) begin
        if (rst) begin
            bit_cnt_ff <= 5'h00;
            addr_ff <= 4'h0;
            shift_ff <= 12'h000;
            sclk_q_ff <= 1'b0;
        end else begin
            bit_cnt_ff <= nxt_bit_cnt;
            addr_ff <= nxt_addr;
            shift_ff <= nxt_shift;
            sclk_q_ff <= sclk;
        end
    end

    // Write lands as the sixteenth bit of a write frame arrives
    assign wr_commit = !sload_n && sclk_rise && !rw && bit_cnt_ff == `SFLL_FRAME_BITS - 5'h01;
    assign wr_data = {sdio_in, shift_ff[11:1]};

    // Register file updates from a completed write
    always_comb begin
        nxt_ctrl_b = ctrl_b_ff;
        nxt_coarse = coarse_ff;
        nxt_fine = fine_ff;
        if (wr_commit) begin
            case (addr_ff)
                `SFLL_ADDR_CTRL_B: nxt_ctrl_b = wr_data;
                `SFLL_ADDR_COARSE: nxt_coarse = wr_data;
                `SFLL_ADDR_FINE: nxt_fine = wr_data;
                default: nxt_ctrl_b = ctrl_b_ff;
            endcase
        end
    end

    // Register file storage
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_b_ff <= `SFLL_CTRL_B_RST;
            coarse_ff <= `SFLL_PERIOD_RST;
            fine_ff <= `SFLL_PERIOD_RST;
        end else begin
            ctrl_b_ff <= nxt_ctrl_b;
            coarse_ff <= nxt_coarse;
            fine_ff <= nxt_fine;
        end
    end

    // Pin drives only during the data part of a read
    assign sdio_out = shift_ff[0];
    assign sdio_oe_n = !(rw && !sload_n && bit_cnt_ff >= `SFLL_ADDR_BITS);

    // Control fields
    assign loop_gain_sel = ctrl_b_ff[`SFLL_GAIN_MSB:`SFLL_GAIN_LSB];
    assign loop_gain_factor = {1'b0, loop_gain_sel} + 4'h1;
    assign feedback_source_sel = ctrl_b_ff[`SFLL_FB_SRC_BIT];
    assign clock_halve_sel = ctrl_b_ff[`SFLL_HALVE_BIT];
    assign position_pulse_sel = ctrl_b_ff[`SFLL_POS_SEL_BIT];
    assign sense_transistor_gain = ctrl_b_ff[`SFLL_SENSE_BIT];
    assign slew_code = ctrl_b_ff[`SFLL_SLEW_MSB:`SFLL_SLEW_LSB];
    assign slew_internal_res = ctrl_b_ff[`SFLL_SLEW_RES_BIT];
    assign mask_short_sel = ctrl_b_ff[`SFLL_MASK_BIT];
    assign coarse_period_value = coarse_ff;
    assign fine_period_value = fine_ff;

    // Test pin becomes an input under external feedback
    assign digital_test_oe_n = feedback_source_sel;
    assign digital_test_out = test_drive_value;

    // Prescaler: steady tick, or every other clock when halving
    always_comb begin
        nxt_half = clock_halve_sel ? !half_ff : 1'b1;
    end

    // Prescaler register
    always_ff @(posedge mclk) begin
        if (rst) begin
            half_ff <= 1'b0;
        end else begin
            half_ff <= nxt_half;
        end
    end

    // Position pulse source select
    always_comb begin
        nxt_pos = position_pulse_sel ? zero_cross_cycle_pulse : bemf_cross_pulse;
    end

    // Position pulse register
    always_ff @(posedge mclk) begin
        if (rst) begin
            pos_ff <= 1'b0;
        end else begin
            pos_ff <= nxt_pos;
        end
    end

    // Loop feedback source select
    always_comb begin
        nxt_fb = feedback_source_sel ? digital_test_in : zero_cross_cycle_pulse;
    end

    // Loop feedback register
    always_ff @(posedge mclk) begin
        if (rst) begin
            fb_ff <= 1'b0;
        end else begin
            fb_ff <= nxt_fb;
        end
    end

    // Registered tick and pulse outputs
    assign clock_tick = half_ff;
    assign position_pulse = pos_ff;
    assign speed_feedback = fb_ff;
    assign fb_evt = nxt_fb && !fb_ff;

    // Period measurement
    sfll_period_meas #(
        .ELEC_PER_REV(ELEC_PER_REV)
    ) u_meas (
        .mclk(mclk),
        .rst(rst),
        .tick(half_ff),
        .cycle_evt(fb_evt),
        .cycle_kind_sel(cycle_kind_sel),
        .coarse_period_value(coarse_ff),
        .fine_period_value(fine_ff),
        .fine_error_value(fine_error_value)
    );
endmodule // sfll_regs
`default_nettype wire

// ---- sfll_regs_props.sv ----
// Checker on the speed-lock-loop register ports
`default_nettype none
module sfll_regs_props (
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic sload_n, // Select
    input wire logic rw, // Read
    input wire logic sdio_oe_n, // Data drive
    input wire logic digital_test_in, // Test in
    input wire logic zero_cross_cycle_pulse, // Cycle
    input wire logic bemf_cross_pulse, // Crossing
    input wire logic digital_test_oe_n, // Test drive
    input wire logic [2:0] loop_gain_sel, // Gain
    input wire logic [3:0] loop_gain_factor, // Factor
    input wire logic feedback_source_sel, // Source
    input wire logic speed_feedback, // Feedback
    input wire logic clock_halve_sel, // Halve
    input wire logic clock_tick, // Tick
    input wire logic position_pulse_sel, // Pulse select
    input wire logic position_pulse, // Pulse
    input wire logic [11:0] coarse_period_value, // Coarse
    input wire logic [11:0] fine_period_value // Fine
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Halving held over two edges
    sequence s_halve; clock_halve_sel ##1 clock_halve_sel; endsequence
    property p_gain; loop_gain_factor == {1'b0, loop_gain_sel} + 4'h1; endproperty
    a_gain: assert property (p_gain) else $error("gain factor");
    property p_dir; digital_test_oe_n == feedback_source_sel; endproperty
    a_dir: assert property (p_dir) else $error("test pin direction");
    property p_fb; !$past(rst) |-> speed_feedback == ($past(feedback_source_sel) ?
        $past(digital_test_in) : $past(zero_cross_cycle_pulse)); endproperty
    a_fb: assert property (p_fb) else $error("feedback source");
    property p_pos; !$past(rst) |-> position_pulse == ($past(position_pulse_sel) ?
        $past(zero_cross_cycle_pulse) : $past(bemf_cross_pulse)); endproperty
    a_pos: assert property (p_pos) else $error("position pulse");
    property p_full; !$past(rst) && !$past(clock_halve_sel) |-> clock_tick; endproperty
    a_full: assert property (p_full) else $error("tick not steady");
    property p_tog; s_halve |-> clock_tick != $past(clock_tick); endproperty
    a_tog: assert property (p_tog) else $error("tick not halved");
    property p_sdio; sload_n || !rw |-> sdio_oe_n; endproperty
    a_sdio: assert property (p_sdio) else $error("data driven off read");
    property p_hold; !$past(rst) && $past(sload_n) |-> $stable(coarse_period_value) &&
        $stable(fine_period_value); endproperty
    a_hold: assert property (p_hold) else $error("period changed idle");
endmodule // sfll_regs_props
bind sfll_regs sfll_regs_props u_props (.*);
`default_nettype wire

// ---- sfll_host.sv ----
// Serial host model for the register port
`default_nettype none
module sfll_host (
    input wire logic mclk, // Clock
    input wire logic sdio_out, // Device data
    input wire logic sdio_oe_n, // Low: device drives
    output logic sclk, // Serial clock
    output logic sload_n, // Frame select
    output logic rw, // 1 read
    output logic sdio_in // Resolved data line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic host_d;
    // Device wins the line while it drives
    assign sdio_in = sdio_oe_n ? host_d : sdio_out;
    initial begin
        sclk = 1'b0;
        sload_n = 1'b1;
        rw = 1'b0;
        host_d = 1'b0;
    end
    // One frame, LSB first; nb below 16 aborts it
    task automatic xfer(input logic [3:0] a, input logic [11:0] d, input logic rd,
        input int nb, output logic [11:0] q);
        logic [15:0] f;
        f = {d, a};
        q = 12'h000;
        @(posedge mclk);
        sload_n <= 1'b0;
        rw <= rd;
        for (int i = 0; i < nb; i++) begin
            @(posedge mclk);
            if (rd && i >= 4) q[i-4] = sdio_out;
            if (!rd || i < 4) host_d <= f[i];
            @(posedge mclk);
            sclk <= 1'b1;
            repeat (2) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        sload_n <= 1'b1;
        rw <= 1'b0;
        host_d <= ~host_d; // Released line flips
        @(posedge mclk);
    endtask
endmodule // sfll_host
`default_nettype wire

// ---- sfll_regs_bench.sv ----
// Self-checking bench for the speed-lock-loop register block
`default_nettype none
module sfll_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, cycle_kind_sel, bemf_cross_pulse, zero_cross_cycle_pulse, rw, sdio_in;
    logic digital_test_in, test_drive_value, sclk, sload_n, sdio_out, sdio_oe_n;
    logic digital_test_out, digital_test_oe_n, feedback_source_sel, speed_feedback;
    logic clock_halve_sel, clock_tick, position_pulse_sel, position_pulse;
    logic sense_transistor_gain, slew_internal_res, mask_short_sel;
    logic [2:0] loop_gain_sel, slew_code;
    logic [3:0] loop_gain_factor;
    logic [11:0] coarse_period_value, fine_period_value, fine_error_value, q;
    logic [11:0] v [4] = '{12'h5aa, 12'ha55, 12'hfff, 12'h000};
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    wire logic [11:0] ctl = {mask_short_sel, slew_internal_res, slew_code,
        sense_transistor_gain, position_pulse_sel, clock_halve_sel, feedback_source_sel,
        loop_gain_sel};
    wire logic [3:0] pins = {speed_feedback, position_pulse, digital_test_oe_n, digital_test_out};
    sfll_regs u_dut (.*);
    sfll_host u_host (.*);
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xf(input logic [3:0] a, input logic [11:0] d, input logic r);
        u_host.xfer(a, d, r, 16, q);
    endtask
    // Cycle pulses 20 clocks apart
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge mclk);
            zero_cross_cycle_pulse <= 1'b1;
            @(posedge mclk);
            zero_cross_cycle_pulse <= 1'b0;
            repeat (18) @(posedge mclk);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        rst = 1'b1;
        cycle_kind_sel = 1'b1;
        bemf_cross_pulse = 1'b0;
        zero_cross_cycle_pulse = 1'b0;
        digital_test_in = 1'b0;
        test_drive_value = 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("ctrl", 12'h000, ctl);
        chk("coarse", 12'h000, coarse_period_value);
        chk("fine", 12'h000, fine_period_value);
        xf(4'h7, 12'h555, 1'b0);
        xf(4'h7, 12'h000, 1'b1);
        chk("error", 12'h000, q);
        foreach (v[i]) begin
            xf(4'h4, v[i], 1'b0);
            chk("ctrl", v[i], ctl);
            digital_test_in <= 1'b1;
            bemf_cross_pulse <= 1'b1;
            repeat (2) @(posedge mclk);
            chk("pin", {8'h00, v[i][3], ~v[i][5], v[i][3], 1'b1}, {8'h00, pins});
            digital_test_in <= 1'b0;
            bemf_cross_pulse <= 1'b0;
        end
        xf(4'h5, 12'hfff, 1'b0);
        xf(4'h6, 12'h7ff, 1'b0);
        xf(4'h9, 12'h123, 1'b0);
        u_host.xfer(4'h5, 12'h001, 1'b0, 10, q);
        chk("coarse", 12'hfff, coarse_period_value);
        chk("fine", 12'h7ff, fine_period_value);
        xf(4'h4, 12'h000, 1'b0);
        xf(4'h5, 12'h001, 1'b0);
        xf(4'h6, 12'h3c5, 1'b0);
        pulses(4);
        xf(4'h7, 12'h000, 1'b1);
        chk("elec", 12'h3c5, q);
        cycle_kind_sel <= 1'b0;
        pulses(12);
        xf(4'h7, 12'h000, 1'b1);
        chk("mech", 12'h001, {11'h000, q < 12'h3c5 && q > 12'h39d});
        end_of_test();
    end
endmodule // sfll_regs_bench
`default_nettype wire
